// >>> gpio_port_pkg.sv
// Constants shared by the general purpose port logic
package gpio_port_pkg;
  // ==========================================================
  // Register addresses
  localparam logic [7:0] ADDR_PORT0_DATA_LATCH        = 8'h80;
  localparam logic [7:0] ADDR_PORT1_DATA_LATCH        = 8'h90;
  localparam logic [7:0] ADDR_PORT0_OUTPUT_DRIVE_MODE = 8'ha4;
  localparam logic [7:0] ADDR_PORT1_OUTPUT_DRIVE_MODE = 8'ha5;
  localparam logic [7:0] ADDR_PORT0_CROSSBAR_BYPASS   = 8'hd4;
  localparam logic [7:0] ADDR_PORT1_CROSSBAR_BYPASS   = 8'hd5;
  localparam logic [7:0] ADDR_PORT0_ANALOG_DIGITAL    = 8'hf1;
  localparam logic [7:0] ADDR_PORT1_ANALOG_DIGITAL    = 8'hf2;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_DATA_LATCH   = 8'hff;
  localparam logic [7:0] RST_DRIVE_MODE   = 8'h00;
  localparam logic [7:0] RST_BYPASS       = 8'h00;
  localparam logic [7:0] RST_ANALOG_DIG   = 8'hff;
  localparam logic [7:0] READ_UNMAPPED    = 8'h00;
  // ==========================================================
  // Bit addressing: upper five bits pick the register, lower three the bit
  localparam int BIT_SEL_MSB = 2;
  localparam int REG_SEL_LSB = 3;
  // Pad states
  typedef enum logic [1:0] {
    PAD_OFF     = 2'b00,
    PAD_DRIVE_0 = 2'b01,
    PAD_DRIVE_1 = 2'b10,
    PAD_FLOAT   = 2'b11
  } pad_state_type;
endpackage

// >>> port_pad_if.sv
// Signals between the port register file and one port's pad control
`timescale 1ns/10ps
`default_nettype none
interface port_pad_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] data_latch;
  logic [WIDTH-1:0] digital_sel;
  logic [WIDTH-1:0] push_pull;
  logic [WIDTH-1:0] assigned;
  logic [WIDTH-1:0] xbar_data;
  logic             global_enable;
  logic [WIDTH-1:0] pin_level;
  modport regs (output data_latch, output digital_sel, output push_pull,
                output assigned, output xbar_data, output global_enable,
                input pin_level);
  modport pad  (input data_latch, input digital_sel, input push_pull,
                input assigned, input xbar_data, input global_enable,
                output pin_level);
endinterface
`default_nettype wire

// >>> port_pad_ctrl.sv
// Pad drive and pin-read control for one 8-bit port
`timescale 1ns/10ps
`default_nettype none
module port_pad_ctrl
  import gpio_port_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset,
  port_pad_if.pad               cfg,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe_n,
  output logic      [WIDTH-1:0] pullup_en
);
  pad_state_type state_next [WIDTH];

  // ==========================================================
  // Per-pin drive decision
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      logic value;
      // Crossbar-owned pins follow their peripheral, free pins the latch
      assign value = cfg.assigned[i] ? cfg.xbar_data[i] : cfg.data_latch[i];
      always_comb begin
        if (!cfg.global_enable || !cfg.digital_sel[i]) begin
          state_next[i] = PAD_OFF;
        end else if (!value) begin
          state_next[i] = PAD_DRIVE_0;
        end else if (cfg.push_pull[i]) begin
          state_next[i] = PAD_DRIVE_1;
        end else begin
          state_next[i] = PAD_FLOAT;
        end
      end
      // Analog pins read zero since their receiver is off
      assign cfg.pin_level[i] = cfg.digital_sel[i] & pin_in[i];

      always_ff @(posedge clk) begin
        if (reset) begin
          pin_out[i]   <= 1'b1;
          pin_oe_n[i]  <= 1'b1;
          pullup_en[i] <= 1'b0;
        end else begin
          case (state_next[i])
            PAD_DRIVE_0: begin
              pin_out[i]  <= 1'b0;
              pin_oe_n[i] <= 1'b0;
            end
            PAD_DRIVE_1: begin
              pin_out[i]  <= 1'b1;
              pin_oe_n[i] <= 1'b0;
            end
            default: begin
              pin_out[i]  <= 1'b1;
              pin_oe_n[i] <= 1'b1;
            end
          endcase
          // Weak pull-up only where a digital pin is not actively driven low
          pullup_en[i] <= cfg.digital_sel[i] && (state_next[i] != PAD_DRIVE_0);
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// >>> general_purpose_port_io.sv
// Register file and pin logic for general purpose ports 0 and 1
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Pins not taken by the crossbar and not analog are plain software-controlled I/O.
// - Each port data register can be read and written as a byte or as single addressed bits.
// - A write to a port data register is held in an output latch that sets the pin level until the next write.
// - A normal read of a port data register returns the pin levels, even for crossbar-assigned pins.
// - Read-modify-write accesses read the output latch instead of the pins and write the result back.
// - Logic, bit-test-and-clear, complement, increment, decrement and single-bit moves use the latch read.
// - A pin in analog mode always reads back as zero on a normal read.
// - With its output mode bit clear, a pin written high floats instead of driving high.
// - An input mode bit of one means digital, zero means analog with pull-up, driver and receiver off.
// - While the crossbar global enable is off, port 0 and 1 drivers are off.
module general_purpose_port_io
  import gpio_port_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [7:0]       sfr_addr,
  input  wire logic             sfr_wr,
  input  wire logic [7:0]       sfr_wdata,
  input  wire logic             sfr_rd,
  input  wire logic             sfr_rmw,
  output logic      [7:0]       sfr_rdata,
  input  wire logic [7:0]       bit_addr,
  input  wire logic             bit_wr,
  input  wire logic             bit_wdata,
  input  wire logic             bit_rd,
  input  wire logic             bit_rmw,
  output logic                  bit_rdata,
  input  wire logic             crossbar_global_enable,
  input  wire logic [WIDTH-1:0] port0_xbar_assigned,
  input  wire logic [WIDTH-1:0] port0_xbar_data,
  input  wire logic [WIDTH-1:0] port1_xbar_assigned,
  input  wire logic [WIDTH-1:0] port1_xbar_data,
  output logic      [WIDTH-1:0] port0_skip,
  output logic      [WIDTH-1:0] port1_skip,
  input  wire logic [WIDTH-1:0] port0_pin_in,
  output logic      [WIDTH-1:0] port0_pin_out,
  output logic      [WIDTH-1:0] port0_pin_oe_n,
  output logic      [WIDTH-1:0] port0_pullup_en,
  input  wire logic [WIDTH-1:0] port1_pin_in,
  output logic      [WIDTH-1:0] port1_pin_out,
  output logic      [WIDTH-1:0] port1_pin_oe_n,
  output logic      [WIDTH-1:0] port1_pullup_en
);
  logic [WIDTH-1:0] port0_data_latch_reg;
  logic [WIDTH-1:0] port1_data_latch_reg;
  logic [WIDTH-1:0] port0_output_drive_mode_reg;
  logic [WIDTH-1:0] port1_output_drive_mode_reg;
  logic [WIDTH-1:0] port0_crossbar_bypass_reg;
  logic [WIDTH-1:0] port1_crossbar_bypass_reg;
  logic [WIDTH-1:0] port0_analog_digital_select_reg;
  logic [WIDTH-1:0] port1_analog_digital_select_reg;
  logic [7:0]       rdata_next;
  logic [7:0]       bit_reg_addr;
  logic [2:0]       bit_index;
  logic [7:0]       bit_byte;
  logic             p0_byte_hit;
  logic             p1_byte_hit;
  logic             p0_bit_hit;
  logic             p1_bit_hit;

  port_pad_if #(.WIDTH(WIDTH)) p0_if ();
  port_pad_if #(.WIDTH(WIDTH)) p1_if ();

  // ==========================================================
  // Register read: pins for normal reads, latch for read-modify-write
  function automatic logic [7:0] read_reg(input logic [7:0] addr, input logic rmw);
    logic [7:0] v;
    v = READ_UNMAPPED;
    case (addr)
      ADDR_PORT0_DATA_LATCH:        v = 8'(rmw ? port0_data_latch_reg : p0_if.pin_level);
      ADDR_PORT1_DATA_LATCH:        v = 8'(rmw ? port1_data_latch_reg : p1_if.pin_level);
      ADDR_PORT0_OUTPUT_DRIVE_MODE: v = 8'(port0_output_drive_mode_reg);
      ADDR_PORT1_OUTPUT_DRIVE_MODE: v = 8'(port1_output_drive_mode_reg);
      ADDR_PORT0_CROSSBAR_BYPASS:   v = 8'(port0_crossbar_bypass_reg);
      ADDR_PORT1_CROSSBAR_BYPASS:   v = 8'(port1_crossbar_bypass_reg);
      ADDR_PORT0_ANALOG_DIGITAL:    v = 8'(port0_analog_digital_select_reg);
      ADDR_PORT1_ANALOG_DIGITAL:    v = 8'(port1_analog_digital_select_reg);
      default:                      v = READ_UNMAPPED;
    endcase
    return v;
  endfunction

  // Only the two data latches are bit addressable
  function automatic logic is_bit_reg(input logic [7:0] addr);
    return (addr == ADDR_PORT0_DATA_LATCH) || (addr == ADDR_PORT1_DATA_LATCH);
  endfunction

  // ==========================================================
  // Bit access decode
  assign bit_reg_addr = {bit_addr[7:REG_SEL_LSB], 3'b000};
  assign bit_index    = bit_addr[BIT_SEL_MSB:0];
  // Bit reads see the latch image of the byte when bit_rmw is set, the pin levels otherwise
  assign bit_byte     = read_reg(bit_reg_addr, bit_rmw);

  // ==========================================================
  // Data latches; a byte write in the same cycle wins over a bit write
  // A bit write that loses to a byte write is dropped, not deferred
  assign p0_byte_hit = sfr_wr && (sfr_addr == ADDR_PORT0_DATA_LATCH);
  assign p1_byte_hit = sfr_wr && (sfr_addr == ADDR_PORT1_DATA_LATCH);
  assign p0_bit_hit  = bit_wr && (bit_reg_addr == ADDR_PORT0_DATA_LATCH);
  assign p1_bit_hit  = bit_wr && (bit_reg_addr == ADDR_PORT1_DATA_LATCH);

  always_ff @(posedge clk) begin
    if (reset) begin
      port0_data_latch_reg <= RST_DATA_LATCH;
    end else if (p0_byte_hit) begin
      port0_data_latch_reg <= sfr_wdata;
    end else if (p0_bit_hit) begin
      port0_data_latch_reg[bit_index] <= bit_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      port1_data_latch_reg <= RST_DATA_LATCH;
    end else if (p1_byte_hit) begin
      port1_data_latch_reg <= sfr_wdata;
    end else if (p1_bit_hit) begin
      port1_data_latch_reg[bit_index] <= bit_wdata;
    end
  end

  // ==========================================================
  // Mode and skip registers
  always_ff @(posedge clk) begin
    if (reset) begin
      port0_output_drive_mode_reg     <= RST_DRIVE_MODE;
      port1_output_drive_mode_reg     <= RST_DRIVE_MODE;
      port0_crossbar_bypass_reg       <= RST_BYPASS;
      port1_crossbar_bypass_reg       <= RST_BYPASS;
      port0_analog_digital_select_reg <= RST_ANALOG_DIG;
      port1_analog_digital_select_reg <= RST_ANALOG_DIG;
    end else if (sfr_wr) begin
      case (sfr_addr)
        ADDR_PORT0_OUTPUT_DRIVE_MODE: port0_output_drive_mode_reg     <= sfr_wdata;
        ADDR_PORT1_OUTPUT_DRIVE_MODE: port1_output_drive_mode_reg     <= sfr_wdata;
        ADDR_PORT0_CROSSBAR_BYPASS:   port0_crossbar_bypass_reg       <= sfr_wdata;
        ADDR_PORT1_CROSSBAR_BYPASS:   port1_crossbar_bypass_reg       <= sfr_wdata;
        ADDR_PORT0_ANALOG_DIGITAL:    port0_analog_digital_select_reg <= sfr_wdata;
        ADDR_PORT1_ANALOG_DIGITAL:    port1_analog_digital_select_reg <= sfr_wdata;
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Read data, one cycle after the strobe; held between reads
  assign rdata_next = read_reg(sfr_addr, sfr_rmw);

  always_ff @(posedge clk) begin
    if (reset) begin
      sfr_rdata <= READ_UNMAPPED;
    end else if (sfr_rd) begin
      sfr_rdata <= rdata_next;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bit_rdata <= 1'b0;
    end else if (bit_rd) begin
      // Bit reads outside the data latches return zero
      bit_rdata <= is_bit_reg(bit_reg_addr) & bit_byte[bit_index];
    end
  end

  // Skip masks feed the external crossbar priority decoder
  always_ff @(posedge clk) begin
    if (reset) begin
      port0_skip <= RST_BYPASS;
      port1_skip <= RST_BYPASS;
    end else begin
      port0_skip <= port0_crossbar_bypass_reg;
      port1_skip <= port1_crossbar_bypass_reg;
    end
  end

  // ==========================================================
  // Pad control
  assign p0_if.data_latch    = port0_data_latch_reg;
  assign p0_if.digital_sel   = port0_analog_digital_select_reg;
  assign p0_if.push_pull     = port0_output_drive_mode_reg;
  // Analog pins are never crossbar-owned
  assign p0_if.assigned      = port0_xbar_assigned & port0_analog_digital_select_reg;
  assign p0_if.xbar_data     = port0_xbar_data;
  assign p0_if.global_enable = crossbar_global_enable;
  assign p1_if.data_latch    = port1_data_latch_reg;
  assign p1_if.digital_sel   = port1_analog_digital_select_reg;
  assign p1_if.push_pull     = port1_output_drive_mode_reg;
  assign p1_if.assigned      = port1_xbar_assigned & port1_analog_digital_select_reg;
  assign p1_if.xbar_data     = port1_xbar_data;
  assign p1_if.global_enable = crossbar_global_enable;

  port_pad_ctrl #(.WIDTH(WIDTH)) u_port0 (
    .clk       (clk),
    .reset     (reset),
    .cfg       (p0_if.pad),
    .pin_in    (port0_pin_in),
    .pin_out   (port0_pin_out),
    .pin_oe_n  (port0_pin_oe_n),
    .pullup_en (port0_pullup_en)
  );

  port_pad_ctrl #(.WIDTH(WIDTH)) u_port1 (
    .clk       (clk),
    .reset     (reset),
    .cfg       (p1_if.pad),
    .pin_in    (port1_pin_in),
    .pin_out   (port1_pin_out),
    .pin_oe_n  (port1_pin_oe_n),
    .pullup_en (port1_pullup_en)
  );
endmodule
`default_nettype wire

// >>> gpio_port_chk.sv
// Checker for the general purpose port block
`timescale 1ns/10ps
`default_nettype none
module gpio_port_chk
  import gpio_port_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic             clk,
  input wire logic             reset,
  input wire logic [7:0]       sfr_addr,
  input wire logic             sfr_wr,
  input wire logic [7:0]       sfr_wdata,
  input wire logic             sfr_rd,
  input wire logic             sfr_rmw,
  input wire logic [7:0]       sfr_rdata,
  input wire logic [7:0]       bit_addr,
  input wire logic             bit_wr,
  input wire logic             bit_wdata,
  input wire logic             bit_rd,
  input wire logic             bit_rmw,
  input wire logic             bit_rdata,
  input wire logic             crossbar_global_enable,
  input wire logic [WIDTH-1:0] port1_xbar_assigned,
  input wire logic [WIDTH-1:0] port0_skip,
  input wire logic [WIDTH-1:0] port0_pin_in,
  input wire logic [WIDTH-1:0] port0_pin_oe_n,
  input wire logic [WIDTH-1:0] port0_pullup_en,
  input wire logic [WIDTH-1:0] port1_pin_out,
  input wire logic [WIDTH-1:0] port1_pin_oe_n
);
  logic [WIDTH-1:0] lat1_reg, mode1_reg, dig0_reg, dig1_reg, byp0_reg;
  // ==========================================================
  // Shadow registers; byte write beats bit write in one cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      lat1_reg <= RST_DATA_LATCH;
      mode1_reg <= RST_DRIVE_MODE;
      dig0_reg <= RST_ANALOG_DIG;
      dig1_reg <= RST_ANALOG_DIG;
      byp0_reg <= RST_BYPASS;
    end else begin
      if (sfr_wr) begin
        case (sfr_addr)
          ADDR_PORT1_DATA_LATCH:        lat1_reg <= sfr_wdata[WIDTH-1:0];
          ADDR_PORT1_OUTPUT_DRIVE_MODE: mode1_reg <= sfr_wdata[WIDTH-1:0];
          ADDR_PORT0_ANALOG_DIGITAL:    dig0_reg <= sfr_wdata[WIDTH-1:0];
          ADDR_PORT1_ANALOG_DIGITAL:    dig1_reg <= sfr_wdata[WIDTH-1:0];
          ADDR_PORT0_CROSSBAR_BYPASS:   byp0_reg <= sfr_wdata[WIDTH-1:0];
          default: ;
        endcase
      end
      // A bit write loses only to a byte write of the same latch
      if (bit_wr && bit_addr[7:3] == 5'h12 && !(sfr_wr && sfr_addr == ADDR_PORT1_DATA_LATCH)) begin
        lat1_reg[bit_addr[2:0]] <= bit_wdata;
      end
    end
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  chk_drivers_held_off: assert property (!crossbar_global_enable |=> &port0_pin_oe_n && &port1_pin_oe_n)
    else $error("port driver on while crossbar disabled");
  chk_open_drain_float: assert property ((~port1_pin_oe_n & port1_pin_out & ~$past(mode1_reg)) == '0)
    else $error("open-drain pin driven high");
  chk_analog_quiet: assert property ((~$past(dig0_reg) & (~port0_pin_oe_n | port0_pullup_en)) == '0)
    else $error("analog pin has driver or pull-up on");
  chk_pin_read_path: assert property (sfr_rd && !sfr_rmw && sfr_addr == ADDR_PORT0_DATA_LATCH
    |=> sfr_rdata == $past(port0_pin_in & dig0_reg)) else $error("port read differs from pins");
  chk_rmw_latch_read: assert property (sfr_rd && sfr_rmw && sfr_addr == ADDR_PORT1_DATA_LATCH
    |=> sfr_rdata == $past(lat1_reg)) else $error("modify read differs from latch");
  chk_bit_latch_read: assert property (bit_rd && bit_rmw && bit_addr[7:3] == 5'h12
    |=> bit_rdata == $past(lat1_reg[bit_addr[2:0]])) else $error("bit modify read differs from latch");
  chk_push_pull_level: assert property (crossbar_global_enable |=> ((port1_pin_oe_n |
    (port1_pin_out ^ $past(lat1_reg))) & $past(dig1_reg & mode1_reg & ~port1_xbar_assigned)) == '0)
    else $error("push-pull pin does not follow latch");
  chk_skip_copy_lag: assert property (port0_skip == $past(byp0_reg))
    else $error("skip output differs from bypass register");
  cover property (sfr_rd && sfr_rmw);
  cover property (bit_rd && bit_rmw);
  cover property (!crossbar_global_enable ##1 crossbar_global_enable);
endmodule
bind general_purpose_port_io gpio_port_chk #(.WIDTH(WIDTH)) chk_u (.clk, .reset, .sfr_addr, .sfr_wr,
  .sfr_wdata, .sfr_rd, .sfr_rmw, .sfr_rdata, .bit_addr, .bit_wr, .bit_wdata, .bit_rd, .bit_rmw, .bit_rdata,
  .crossbar_global_enable, .port1_xbar_assigned, .port0_skip, .port0_pin_in, .port0_pin_oe_n,
  .port0_pullup_en, .port1_pin_out, .port1_pin_oe_n);
`default_nettype wire

// >>> gpio_board_model.sv
// Board-side model of one port's package pins
`timescale 1ns/10ps
`default_nettype none
module gpio_board_model (
  input  wire logic       clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  input  wire logic [7:0] pullup_en,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin_level
);
  // A pin nobody holds has no defined level, so it shows a changing pattern
  logic [7:0] drift_reg = 8'h55;
  always_ff @(posedge clk) begin
    drift_reg <= ~drift_reg;
  end
  assign pin_level = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
                   | (pin_oe_n & ~ext_en & (pullup_en | drift_reg));
endmodule
`default_nettype wire

// >>> test_general_purpose_port_io.sv
// Testbench for the general purpose port block
`timescale 1ns/10ps
`default_nettype none
module test_general_purpose_port_io import gpio_port_pkg::*;;
  logic clk = 1'b0, reset = 1'b1, enable = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_rmw = 1'b0;
  logic bit_wr = 1'b0, bit_wdata = 1'b0, bit_rd = 1'b0, bit_rmw = 1'b0, bit_rdata;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, bit_addr = 8'h00, asg0 = 8'h00, dat0 = 8'h00;
  logic [7:0] asg1 = 8'h00, dat1 = 8'h00, ext_en1 = 8'h00, ext_val1 = 8'h00, sfr_rdata, skip0, skip1;
  logic [7:0] pin0_in, pin0_out, oe0_n, pu0, pin1_in, pin1_out, oe1_n, pu1;
  int         err_total = 0, checks_done = 0;
  general_purpose_port_io dut_u (.clk, .reset, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rmw, .sfr_rdata,
    .bit_addr, .bit_wr, .bit_wdata, .bit_rd, .bit_rmw, .bit_rdata, .crossbar_global_enable(enable),
    .port0_xbar_assigned(asg0), .port0_xbar_data(dat0), .port1_xbar_assigned(asg1), .port1_xbar_data(dat1),
    .port0_skip(skip0), .port1_skip(skip1), .port0_pin_in(pin0_in), .port0_pin_out(pin0_out),
    .port0_pin_oe_n(oe0_n), .port0_pullup_en(pu0), .port1_pin_in(pin1_in), .port1_pin_out(pin1_out),
    .port1_pin_oe_n(oe1_n), .port1_pullup_en(pu1));
  gpio_board_model brd0_u (.clk, .pin_out(pin0_out), .pin_oe_n(oe0_n), .pullup_en(pu0), .ext_en(8'h00),
    .ext_val(8'h00), .pin_level(pin0_in));
  gpio_board_model brd1_u (.clk, .pin_out(pin1_out), .pin_oe_n(oe1_n), .pullup_en(pu1), .ext_en(ext_en1),
    .ext_val(ext_val1), .pin_level(pin1_in));
  always #4 clk = ~clk;
  // ==========================================================
  // Access tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] exp);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rmw <= m;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1 check(sfr_rdata, exp);
  endtask
  task automatic bwr(input logic [7:0] a, input logic d);
    @(posedge clk);
    bit_addr <= a;
    bit_wdata <= d;
    bit_wr <= 1'b1;
    @(posedge clk);
    bit_wr <= 1'b0;
  endtask
  task automatic brd(input logic [7:0] a, input logic m, input logic e);
    @(posedge clk);
    bit_addr <= a;
    bit_rmw <= m;
    bit_rd <= 1'b1;
    @(posedge clk);
    bit_rd <= 1'b0;
    #1 check({7'h00, bit_rdata}, {7'h00, e});
  endtask
  // Pin outputs trail a register change by one edge
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Test sequence
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rd(ADDR_PORT0_CROSSBAR_BYPASS, 1'b0, RST_BYPASS);
    rd(ADDR_PORT1_DATA_LATCH, 1'b1, RST_DATA_LATCH);
    wr(ADDR_PORT0_DATA_LATCH, 8'h00);
    settle();
    check(oe0_n, 8'hff);
    rd(ADDR_PORT0_DATA_LATCH, 1'b0, 8'hff);
    @(posedge clk) enable <= 1'b1;
    wr(ADDR_PORT0_DATA_LATCH, 8'hff);
    wr(ADDR_PORT1_DATA_LATCH, 8'ha5);
    wr(ADDR_PORT1_OUTPUT_DRIVE_MODE, 8'h0f);
    settle();
    check(oe1_n, 8'ha0);
    check(pin1_out, 8'ha5);
    rd(ADDR_PORT1_DATA_LATCH, 1'b0, 8'ha5);
    rd(ADDR_PORT1_OUTPUT_DRIVE_MODE, 1'b0, 8'h0f);
    @(posedge clk) ext_en1 <= 8'h80;
    rd(ADDR_PORT1_DATA_LATCH, 1'b0, 8'h25);
    rd(ADDR_PORT1_DATA_LATCH, 1'b1, 8'ha5);
    brd(8'h97, 1'b0, 1'b0);
    brd(8'h97, 1'b1, 1'b1);
    bwr(8'h90, 1'b0);
    rd(ADDR_PORT1_DATA_LATCH, 1'b1, 8'ha4);
    wr(ADDR_PORT0_OUTPUT_DRIVE_MODE, 8'hff);
    @(posedge clk);
    asg1 <= 8'h01;
    dat1 <= 8'h01;
    asg0 <= 8'h0f;
    dat0 <= 8'h05;
    settle();
    check(pin0_out, 8'hf5);
    check(oe0_n, 8'h00);
    rd(ADDR_PORT1_DATA_LATCH, 1'b0, 8'h25);
    bwr(8'ha0, 1'b1);
    brd(8'ha0, 1'b0, 1'b0);
    wr(8'hc0, 8'h5a);
    rd(8'hc0, 1'b0, READ_UNMAPPED);
    wr(ADDR_PORT0_ANALOG_DIGITAL, 8'hf0);
    settle();
    check(pu0, 8'hf0);
    rd(ADDR_PORT0_DATA_LATCH, 1'b0, 8'hf0);
    wr(ADDR_PORT0_CROSSBAR_BYPASS, 8'h3c);
    wr(ADDR_PORT1_CROSSBAR_BYPASS, 8'hc3);
    wr(ADDR_PORT1_ANALOG_DIGITAL, 8'h7f);
    settle();
    check(skip0, 8'h3c);
    check(skip1, 8'hc3);
    check(pu1, 8'h25);
    @(posedge clk) enable <= 1'b0;
    settle();
    check(oe1_n, 8'hff);
    check(pu1, 8'h7f);
    close_out();
  end
  initial begin
    repeat (2000) @(posedge clk);
    err_total++;
    close_out();
  end
endmodule
`default_nettype wire
